/* rtl/acl_cap_regs.v */
// Access-control and latency-tolerance capability registers, Wishbone slave
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "acl_consts.vh"

module acl_cap_regs (
  // Clock, reset and enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Port role: high on the upstream port, same-domain static strap
  input wire upstream_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Settings for the routing and power logic
  output reg [6:0] acs_en_o,
  output reg [7:0] egress_block_o,
  output reg [9:0] snoop_lat_val_o,
  output reg [2:0] snoop_lat_scale_o
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [6:0] acs_en_q;
  reg [7:0] egress_q;
  reg [9:0] snoop_val_q;
  reg [2:0] snoop_scl_q;

  wire req;
  wire hit_acs_ctrl;
  wire hit_egress;
  wire hit_snoop;
  wire [31:0] acs_ctrl_word;
  wire [31:0] egress_word;
  wire [31:0] snoop_word;
  wire [31:0] acs_ctrl_new;
  wire [31:0] egress_new;
  wire [31:0] snoop_new;
  reg [31:0] rd_word;

  // Header word from identifier; pointer is shared by both headers
  function [31:0] cap_header;
    input [15:0] id;
    begin
      // Fields sit back to back: pointer, version, identifier
      cap_header = {`ACL_NEXT_PTR, `ACL_CAP_VER, id};
    end
  endfunction

  // Which words exist on this port
  function present;
    input [11:0] adr;
    input up;
    begin
      case (adr)
        `ACL_OFS_ACS_HDR,
        `ACL_OFS_ACS_CTRL,
        `ACL_OFS_EGRESS:
          present = ~up;
        `ACL_OFS_LTR_HDR,
        `ACL_OFS_SNOOP:
          present = up;
        default:
          present = 1'b0;
      endcase
    end
  endfunction

  assign req = cyc_i & stb_i & (state_q == ST_IDLE);
  assign hit_acs_ctrl = present(adr_i, upstream_i) &&
                        (adr_i == `ACL_OFS_ACS_CTRL);
  assign hit_egress = present(adr_i, upstream_i) &&
                      (adr_i == `ACL_OFS_EGRESS);
  assign hit_snoop = present(adr_i, upstream_i) &&
                     (adr_i == `ACL_OFS_SNOOP);

  ////////////////////////////////////////////////////////////////////////
  // Register words as seen by software

  assign acs_ctrl_word = ({25'h0000000, acs_en_q} << `ACL_FEAT_EN_LSB) |
                         ({24'h000000, `ACL_VEC_SIZE_VAL}
                           << `ACL_VEC_SIZE_LSB) |
                         ({25'h0000000, `ACL_FEAT_CAP_VAL}
                           << `ACL_FEAT_CAP_LSB);
  assign egress_word = {24'h000000, egress_q};
  assign snoop_word = ({29'h00000000, snoop_scl_q} << `ACL_SNOOP_SCL_LSB) |
                      ({22'h000000, snoop_val_q} << `ACL_SNOOP_VAL_LSB);

  // Only the enable bits are writable in the control word
  acl_wr_merge u_merge_ctrl (
    .old_i(acs_ctrl_word),
    .wdat_i(dat_i),
    .sel_i(sel_i),
    .wmask_i(32'h007F0000),
    .new_o(acs_ctrl_new)
  );

  acl_wr_merge u_merge_egress (
    .old_i(egress_word),
    .wdat_i(dat_i),
    .sel_i(sel_i),
    .wmask_i(32'h000000FF),
    .new_o(egress_new)
  );

  // Reserved bits 15:13 and the no-snoop half are not writable here
  acl_wr_merge u_merge_snoop (
    .old_i(snoop_word),
    .wdat_i(dat_i),
    .sel_i(sel_i),
    .wmask_i(32'h00001FFF),
    .new_o(snoop_new)
  );

  // Unmapped or absent words read zero and still acknowledge
  always @* begin
    rd_word = 32'h00000000;
    if (present(adr_i, upstream_i)) begin
      case (adr_i)
        `ACL_OFS_ACS_HDR: rd_word = cap_header(`ACL_ACS_ID);
        `ACL_OFS_ACS_CTRL: rd_word = acs_ctrl_word;
        `ACL_OFS_EGRESS: rd_word = egress_word;
        `ACL_OFS_LTR_HDR: rd_word = cap_header(`ACL_LTR_ID);
        `ACL_OFS_SNOOP: rd_word = snoop_word;
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // One cycle of ack, then a mandatory idle cycle so a held strobe
  // is not taken twice
  always @* begin
    case (state_q)
      ST_IDLE: state_d = req ? ST_ACK : ST_IDLE;
      ST_ACK: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else if (ce_i) begin
      state_q <= state_d;
      ack_o <= req;
      dat_o <= (req && !we_i) ? rd_word : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Writable fields

  always @(posedge clk_i) begin
    if (rst_i) begin
      acs_en_q <= `ACL_FEAT_EN_RST;
      egress_q <= `ACL_EGRESS_RST;
      snoop_val_q <= `ACL_SNOOP_VAL_RST;
      snoop_scl_q <= `ACL_SNOOP_SCL_RST;
    end else if (ce_i && req && we_i) begin
      if (hit_acs_ctrl)
        acs_en_q <= acs_ctrl_new[`ACL_FEAT_EN_LSB +: `ACL_FEAT_NUM];
      if (hit_egress)
        egress_q <= egress_new[`ACL_EGRESS_W-1:0];
      if (hit_snoop) begin
        snoop_val_q <= snoop_new[`ACL_SNOOP_VAL_LSB +: `ACL_SNOOP_VAL_W];
        snoop_scl_q <= snoop_new[`ACL_SNOOP_SCL_LSB +: `ACL_SNOOP_SCL_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to routing and power logic, registered; masked off on the wrong port

  always @(posedge clk_i) begin
    if (rst_i) begin
      acs_en_o <= `ACL_FEAT_EN_RST;
      egress_block_o <= `ACL_EGRESS_RST;
      snoop_lat_val_o <= `ACL_SNOOP_VAL_RST;
      snoop_lat_scale_o <= `ACL_SNOOP_SCL_RST;
    end else if (ce_i) begin
      acs_en_o <= upstream_i ? 7'h00 : acs_en_q;
      egress_block_o <= upstream_i ? 8'h00 : egress_q;
      snoop_lat_val_o <= upstream_i ? snoop_val_q : 10'h000;
      snoop_lat_scale_o <= upstream_i ? snoop_scl_q : 3'h0;
    end
  end

endmodule

/* inc/acl_consts.vh */
// Offsets, field positions and reset values of the capability register bank
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// Word offsets of the bank
`define ACL_OFS_ACS_HDR 12'h220
`define ACL_OFS_ACS_CTRL 12'h224
`define ACL_OFS_EGRESS 12'h228
`define ACL_OFS_LTR_HDR 12'h230
`define ACL_OFS_SNOOP 12'h234

// Capability header fields
`define ACL_HDR_ID_LSB 0
`define ACL_HDR_VER_LSB 16
`define ACL_HDR_NEXT_LSB 20
`define ACL_ACS_ID 16'h000D
`define ACL_LTR_ID 16'h0018
`define ACL_CAP_VER 4'h1
`define ACL_NEXT_PTR 12'h240

// Access-control capability/control word
`define ACL_FEAT_NUM 7
`define ACL_FEAT_CAP_LSB 0
`define ACL_FEAT_CAP_VAL 7'h7F
`define ACL_VEC_SIZE_LSB 8
`define ACL_VEC_SIZE_VAL 8'h08
`define ACL_FEAT_EN_LSB 16
`define ACL_FEAT_EN_RST 7'h00

// Egress control vector
`define ACL_EGRESS_W 8
`define ACL_EGRESS_RST 8'h00

// Snoop latency word
`define ACL_SNOOP_VAL_LSB 0
`define ACL_SNOOP_VAL_W 10
`define ACL_SNOOP_VAL_RST 10'h000
`define ACL_SNOOP_SCL_LSB 10
`define ACL_SNOOP_SCL_W 3
`define ACL_SNOOP_SCL_RST 3'h0

`endif

/* rtl/acl_wr_merge.v */
// Byte-enable write merge for one register word
`timescale 1ns/100ps

module acl_wr_merge (
  // Old contents and bus write
  input wire [31:0] old_i,
  input wire [31:0] wdat_i,
  input wire [3:0] sel_i,
  // Bits that software may change
  input wire [31:0] wmask_i,
  // Merged word
  output wire [31:0] new_o
);

  wire [31:0] lane_mask;

  assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Read-only and reserved bits keep their value
  assign new_o = (old_i & ~(lane_mask & wmask_i)) |
                 (wdat_i & lane_mask & wmask_i);

endmodule

/* tb/acl_cap_checker.sv */
// Bus and field checks for the capability register bank
`timescale 1ns/100ps

module acl_cap_checker (
  // Clock, reset, role and bus (grouped to keep the checker short)
  input wire clk_i, rst_i, ce_i, upstream_i, cyc_i, stb_i, we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i, dat_o,
  input wire ack_o,
  // Field outputs
  input wire [6:0] acs_en_o,
  input wire [7:0] egress_block_o,
  input wire [9:0] snoop_lat_val_o,
  input wire [2:0] snoop_lat_scale_o
);
  reg [11:0] adr_q;
  reg we_q;
  wire rd = ack_o && !we_q;
  wire [27:0] flds = {acs_en_o, egress_block_o, snoop_lat_val_o,
                      snoop_lat_scale_o};
  // Request of the taking edge, seen again in the ack cycle
  always @(posedge clk_i) begin
    adr_q <= adr_i;
    we_q <= we_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_acs_hdr: assert property (rd && adr_q == 12'h220
    && !upstream_i |-> dat_o == 32'h2401000D) else $error("bad acs header");
  a_ltr_hdr: assert property (rd && adr_q == 12'h230
    && upstream_i |-> dat_o == 32'h24010018) else $error("bad ltr header");
  a_cap_word: assert property (rd && adr_q == 12'h224
    && !upstream_i |-> dat_o == {9'h0, acs_en_o, 16'h087F})
    else $error("bad capability word");
  a_egress_read: assert property (rd && adr_q == 12'h228
    && !upstream_i |-> dat_o == {24'h0, egress_block_o})
    else $error("bad egress read");
  a_snoop_read: assert property (rd && adr_q == 12'h234
    && upstream_i |-> dat_o == {19'h0, snoop_lat_scale_o, snoop_lat_val_o})
    else $error("bad snoop read");
  a_role_gate: assert property (rd && (upstream_i ? adr_q < 12'h230
    : adr_q >= 12'h230) |-> dat_o == 32'h0) else $error("absent word read");
  a_reset_zero: assert property ($fell(rst_i) |-> flds == 28'h0)
    else $error("fields not cleared");
  a_write_only: assert property ($changed(flds)
    |-> $past(ack_o) && $past(we_i, 2)) else $error("field moved unasked");
  a_egress_write: assert property ($past(ack_o) && $past(we_i, 2)
    && $past(adr_i, 2) == 12'h228 && $past(sel_i, 2) == 4'hF && !upstream_i
    |-> {24'h0, egress_block_o} == ($past(dat_i, 2) & 32'h000000FF))
    else $error("egress write lost");
  a_ack_next: assert property (cyc_i && stb_i && ce_i && !ack_o
    && !$past(ack_o) |=> ack_o) else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
endmodule

bind acl_cap_regs acl_cap_checker u_acl_cap_checker (.*);

/* tb/acl_cap_regs_tb.sv */
// Self-checking bench for the capability register bank
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module acl_cap_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic upstream_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  wire [31:0] dat_o;
  wire ack_o;
  wire [6:0] acs_en_o;
  wire [7:0] egress_block_o;
  wire [9:0] snoop_lat_val_o;
  wire [2:0] snoop_lat_scale_o;
  int mismatches = 0;
  int compares = 0;
  logic [49:0] r;
  logic [31:0] rd_q;
  // Row: {upstream, write}, address, lanes, write data or expected read
  logic [49:0] rows [0:26] = '{
    50'h0_220_F_2401000D, 50'h0_224_F_0000087F, 50'h0_228_F_00000000,
    50'h0_230_F_00000000, 50'h0_234_F_00000000, 50'h1_224_F_FFFFFFFF,
    50'h0_224_F_007F087F, 50'h1_224_B_00000000, 50'h0_224_F_007F087F,
    50'h1_228_F_A5A5A5A5, 50'h0_228_F_000000A5, 50'h1_220_F_FFFFFFFF,
    50'h0_220_F_2401000D, 50'h2_230_F_24010018, 50'h2_234_F_00000000,
    50'h2_220_F_00000000, 50'h2_228_F_00000000, 50'h3_234_F_FFFFFFFF,
    50'h2_234_F_00001FFF, 50'h3_228_F_FFFFFFFF, 50'h2_228_F_00000000,
    50'h2_300_F_00000000, 50'h3_234_1_00000005, 50'h2_234_F_00001F05,
    50'h0_228_F_00000000, 50'h0_224_F_0000087F, 50'h0_300_F_00000000};

  acl_cap_regs u_acl_cap_regs (.*);

  initial forever #5 clk_i = ~clk_i;

  task finish_test;
    begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  // Role is a static strap, so it only moves under reset
  task reset_dut(input logic up);
    begin
      upstream_i <= up;
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      `CHK({acs_en_o, egress_block_o, snoop_lat_val_o, snoop_lat_scale_o},
           28'h0)
    end
  endtask

  task bus(input logic w, input logic [11:0] a, input logic [3:0] s,
           input logic [31:0] d, output logic [31:0] q);
    int n;
    begin
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      do begin
        @(posedge clk_i);
        n++;
      end while (ack_o !== 1'b1 && n < 20);
      q = dat_o;
      if (n >= 20) begin
        mismatches++;
        finish_test();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  initial begin
    for (int i = 0; i < 27; i++) begin
      r = rows[i];
      if (i == 0 || r[49] !== upstream_i) reset_dut(r[49]);
      bus(r[48], r[47:36], r[35:32], r[31:0], rd_q);
      if (!r[48]) `CHK(rd_q, r[31:0])
      if (r[49:36] == 14'h1228) `CHK(egress_block_o, r[7:0])
      $display("row %0d done", i);
    end
    // Frozen enable: a held request waits, then is taken once enabled
    ce_i <= 1'b0;
    fork
      bus(1'b1, 12'h228, 4'hF, 32'h0000003C, rd_q);
      begin
        repeat (4) @(posedge clk_i);
        `CHK(ack_o, 1'b0)
        `CHK(egress_block_o, 8'h00)
        ce_i <= 1'b1;
      end
    join
    `CHK(egress_block_o, 8'h3C)
    bus(1'b1, 12'h224, 4'h4, 32'h00550000, rd_q);
    `CHK(acs_en_o, 7'h55)
    $display("enable test done");
    // Mid-run reset into the upstream role, then latency outputs
    reset_dut(1'b1);
    bus(1'b1, 12'h234, 4'h3, 32'hFFFF1A2B, rd_q);
    `CHK(snoop_lat_val_o, 10'h22B)
    `CHK(snoop_lat_scale_o, 3'h6)
    `CHK(acs_en_o, 7'h00)
    `CHK(egress_block_o, 8'h00)
    $display("latency test done");
    finish_test();
  end
endmodule
